// [ipe_map.vh]
// Purpose: Register offsets, bit positions and reset values of the interrupt priority block
// Assumes: 8-bit special-function register port from the core
// Notes: Bit positions are shared by enable and priority registers of the extended group
// Contract
// R1: Base priority bit 7 unused, always reads one, writes ignored.
// R2: Base priority bit 6 sets serial peripheral priority, one is high.
// R3: Base priority bit 4 sets asynchronous serial priority, one is high.
// R4: Base priority bits 5, 3, 1 set timer 2, 1, 0 priority.
// R5: Base priority bits 2, 0 set external interrupt 1, 0 priority.
// R6: Extended enable bit 7 gates timer 3 low or high overflow requests.
// R7: Extended enable bit 6 gates comparator 1 rise or fall requests.
// R8: Extended enable bit 5 gates comparator 0 rise or fall requests.
// R9: Extended enable bit 4 gates all counter array requests.
// R10: Extended enable bit 3 gates the conversion-done request.
// R11: Extended enable bit 2 gates the window compare request.
// R12: Extended enable bit 1 gates the calendar alarm request.
// R13: Extended enable bit 0 gates all two-wire port requests.
// R14: Extended priority bit 7 sets timer 3 priority, one is high.
// R15: Extended priority bit 6 sets comparator 1 priority, one is high.
// R16: Extended priority bit 5 sets comparator 0 priority, one is high.
// R17: Extended priority bit 4 sets counter array priority, one is high.
// R18: Extended priority bit 3 sets conversion-done priority, one is high.
// R19: Extended priority bit 2 sets window compare priority, one is high.
// R20: Extended priority bit 1 sets calendar alarm priority, one is high.
// R21: Extended priority bit 0 sets two-wire port priority, one is high.
// R22: Global enable low blocks every source regardless of individual masks.
// R23: Enabled high-level requests win over low-level and may preempt low service.
`ifndef IPE_MAP_VH
`define IPE_MAP_VH
`define IPE_ADDR_BASE_PRIO 8'hB8
`define IPE_ADDR_EXT_EN1 8'hE6
`define IPE_ADDR_EXT_PRIO1 8'hF6
`define IPE_RST_BASE_PRIO 8'h80
`define IPE_RST_EXT_EN1 8'h00
`define IPE_RST_EXT_PRIO1 8'h00
`define IPE_BASE_PRIO_WMASK 8'h7F
`define IPE_BIT_UNUSED 7
`define IPE_BIT_SERIAL_PERIPH 6
`define IPE_BIT_TIMER_TWO 5
`define IPE_BIT_ASYNC_SERIAL 4
`define IPE_BIT_TIMER_ONE 3
`define IPE_BIT_EXT_ONE 2
`define IPE_BIT_TIMER_ZERO 1
`define IPE_BIT_EXT_ZERO 0
`define IPE_BIT_TIMER_THREE 7
`define IPE_BIT_COMP_ONE 6
`define IPE_BIT_COMP_ZERO 5
`define IPE_BIT_COUNTER_ARRAY 4
`define IPE_BIT_CONV_DONE 3
`define IPE_BIT_CONV_WINDOW 2
`define IPE_BIT_CAL_ALARM 1
`define IPE_BIT_TWO_WIRE 0
`endif

// [ipe_prio_enable.v]
// Purpose: Base priority, first extended enable and first extended priority registers
// Assumes: Core reaches registers over an 8-bit address, write strobe and read data port
// Notes: Produces masked high and low level request summaries for the vector arbiter
`timescale 1ns/1ps
`include "ipe_map.vh"
module ipe_prio_enable (
	input wire mclk,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	output wire sfr_hit,
	input wire global_irq_enable,
	input wire base_enable_serial_periph,
	input wire base_enable_timer_two,
	input wire base_enable_async_serial,
	input wire base_enable_timer_one,
	input wire base_enable_ext_one,
	input wire base_enable_timer_zero,
	input wire base_enable_ext_zero,
	input wire serial_periph_req,
	input wire timer_two_req,
	input wire async_serial_req,
	input wire timer_one_req,
	input wire ext_irq_one_req,
	input wire timer_zero_req,
	input wire ext_irq_zero_req,
	input wire timer_three_low_overflow,
	input wire timer_three_high_overflow,
	input wire comparator_one_rise_flag,
	input wire comparator_one_fall_flag,
	input wire comparator_zero_rise_flag,
	input wire comparator_zero_fall_flag,
	input wire counter_array_req,
	input wire conversion_done_flag,
	input wire window_compare_flag,
	input wire calendar_alarm_req,
	input wire two_wire_req,
	input wire in_high_service,
	input wire in_low_service,
	output wire [14:0] high_req,
	output wire [14:0] low_req,
	output wire irq_high,
	output wire irq_low,
	output wire [7:0] base_prio_out,
	output wire [7:0] ext_en1_out,
	output wire [7:0] ext_prio1_out
);
	localparam [7:0] BASE_PRIO_RST = `IPE_RST_BASE_PRIO;
	localparam [7:0] BASE_PRIO_WMASK = `IPE_BASE_PRIO_WMASK;
	localparam [7:0] EXT_EN1_RST = `IPE_RST_EXT_EN1;
	localparam [7:0] EXT_PRIO1_RST = `IPE_RST_EXT_PRIO1;
	localparam [2:0] SEL_NONE = 3'h0;
	localparam [2:0] SEL_BASE_PRIO = 3'h1;
	localparam [2:0] SEL_EXT_EN1 = 3'h2;
	localparam [2:0] SEL_EXT_PRIO1 = 3'h4;

	// One-hot register select, shared by write, read and hit decoding
	function [2:0] ipe_reg_select;
		input [7:0] addr;
		begin
			if (addr == `IPE_ADDR_BASE_PRIO) begin
				ipe_reg_select = SEL_BASE_PRIO;
			end else if (addr == `IPE_ADDR_EXT_EN1) begin
				ipe_reg_select = SEL_EXT_EN1;
			end else if (addr == `IPE_ADDR_EXT_PRIO1) begin
				ipe_reg_select = SEL_EXT_PRIO1;
			end else begin
				ipe_reg_select = SEL_NONE;
			end
		end
	endfunction

	wire [2:0] reg_sel;
	wire wr_base_prio;
	wire wr_ext_en1;
	wire wr_ext_prio1;
	reg [6:0] base_prio_q;
	reg [6:0] base_prio_d;
	reg [7:0] ext_en1_q;
	reg [7:0] ext_en1_d;
	reg [7:0] ext_prio1_q;
	reg [7:0] ext_prio1_d;
	wire [7:0] base_prio_view;
	wire serial_periph_prio;
	wire timer_two_prio;
	wire async_serial_prio;
	wire timer_one_prio;
	wire ext_irq_one_prio;
	wire timer_zero_prio;
	wire ext_irq_zero_prio;
	wire timer_three_enable;
	wire comparator_one_enable;
	wire comparator_zero_enable;
	wire counter_array_enable;
	wire conv_done_enable;
	wire conv_window_enable;
	wire calendar_alarm_enable;
	wire two_wire_enable;
	wire timer_three_prio;
	wire comparator_one_prio;
	wire comparator_zero_prio;
	wire counter_array_prio;
	wire conv_done_prio;
	wire conv_window_prio;
	wire calendar_alarm_prio;
	wire two_wire_prio;
	wire serial_periph_raw;
	wire timer_two_raw;
	wire async_serial_raw;
	wire timer_one_raw;
	wire ext_irq_one_raw;
	wire timer_zero_raw;
	wire ext_irq_zero_raw;
	wire timer_three_raw;
	wire comparator_one_raw;
	wire comparator_zero_raw;
	wire counter_array_raw;
	wire conv_done_raw;
	wire conv_window_raw;
	wire calendar_alarm_raw;
	wire two_wire_raw;
	wire serial_periph_pend;
	wire timer_two_pend;
	wire async_serial_pend;
	wire timer_one_pend;
	wire ext_irq_one_pend;
	wire timer_zero_pend;
	wire ext_irq_zero_pend;
	wire timer_three_pend;
	wire comparator_one_pend;
	wire comparator_zero_pend;
	wire counter_array_pend;
	wire conv_done_pend;
	wire conv_window_pend;
	wire calendar_alarm_pend;
	wire two_wire_pend;
	wire [14:0] src_pend;
	wire [14:0] src_prio;

	assign reg_sel = ipe_reg_select(sfr_addr);
	assign wr_base_prio = sfr_wr & reg_sel[0];
	assign wr_ext_en1 = sfr_wr & reg_sel[1];
	assign wr_ext_prio1 = sfr_wr & reg_sel[2];

	// Bit 7 is not stored at all, so a write there cannot land
	always @* begin
		base_prio_d = base_prio_q;
		if (wr_base_prio) begin
			base_prio_d = sfr_wdata[6:0] & BASE_PRIO_WMASK[6:0]; // R1
		end
	end

	always @* begin
		ext_en1_d = ext_en1_q;
		if (wr_ext_en1) begin
			ext_en1_d = sfr_wdata;
		end
	end

	always @* begin
		ext_prio1_d = ext_prio1_q;
		if (wr_ext_prio1) begin
			ext_prio1_d = sfr_wdata;
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			base_prio_q <= BASE_PRIO_RST[6:0];
		end else begin
			base_prio_q <= base_prio_d;
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			ext_en1_q <= EXT_EN1_RST;
		end else begin
			ext_en1_q <= ext_en1_d;
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			ext_prio1_q <= EXT_PRIO1_RST;
		end else begin
			ext_prio1_q <= ext_prio1_d;
		end
	end

	// Unused top bit always reads back as one
	assign base_prio_view = {1'b1, base_prio_q}; // R1

	always @* begin
		if (reg_sel[0]) begin
			sfr_rdata = base_prio_view;
		end else if (reg_sel[1]) begin
			sfr_rdata = ext_en1_q;
		end else if (reg_sel[2]) begin
			sfr_rdata = ext_prio1_q;
		end else begin
			sfr_rdata = 8'h00;
		end
	end

	assign sfr_hit = |reg_sel;

	// Base group priority fields
	assign serial_periph_prio = base_prio_q[`IPE_BIT_SERIAL_PERIPH]; // R2
	assign timer_two_prio = base_prio_q[`IPE_BIT_TIMER_TWO]; // R4
	assign async_serial_prio = base_prio_q[`IPE_BIT_ASYNC_SERIAL]; // R3
	assign timer_one_prio = base_prio_q[`IPE_BIT_TIMER_ONE]; // R4
	assign ext_irq_one_prio = base_prio_q[`IPE_BIT_EXT_ONE]; // R5
	assign timer_zero_prio = base_prio_q[`IPE_BIT_TIMER_ZERO]; // R4
	assign ext_irq_zero_prio = base_prio_q[`IPE_BIT_EXT_ZERO]; // R5

	// First extended group enable fields
	assign timer_three_enable = ext_en1_q[`IPE_BIT_TIMER_THREE]; // R6
	assign comparator_one_enable = ext_en1_q[`IPE_BIT_COMP_ONE]; // R7
	assign comparator_zero_enable = ext_en1_q[`IPE_BIT_COMP_ZERO]; // R8
	assign counter_array_enable = ext_en1_q[`IPE_BIT_COUNTER_ARRAY]; // R9
	assign conv_done_enable = ext_en1_q[`IPE_BIT_CONV_DONE]; // R10
	assign conv_window_enable = ext_en1_q[`IPE_BIT_CONV_WINDOW]; // R11
	assign calendar_alarm_enable = ext_en1_q[`IPE_BIT_CAL_ALARM]; // R12
	assign two_wire_enable = ext_en1_q[`IPE_BIT_TWO_WIRE]; // R13

	// First extended group priority fields
	assign timer_three_prio = ext_prio1_q[`IPE_BIT_TIMER_THREE]; // R14
	assign comparator_one_prio = ext_prio1_q[`IPE_BIT_COMP_ONE]; // R15
	assign comparator_zero_prio = ext_prio1_q[`IPE_BIT_COMP_ZERO]; // R16
	assign counter_array_prio = ext_prio1_q[`IPE_BIT_COUNTER_ARRAY]; // R17
	assign conv_done_prio = ext_prio1_q[`IPE_BIT_CONV_DONE]; // R18
	assign conv_window_prio = ext_prio1_q[`IPE_BIT_CONV_WINDOW]; // R19
	assign calendar_alarm_prio = ext_prio1_q[`IPE_BIT_CAL_ALARM]; // R20
	assign two_wire_prio = ext_prio1_q[`IPE_BIT_TWO_WIRE]; // R21

	// Paired flags merge into one source before masking
	assign serial_periph_raw = serial_periph_req;
	assign timer_two_raw = timer_two_req;
	assign async_serial_raw = async_serial_req;
	assign timer_one_raw = timer_one_req;
	assign ext_irq_one_raw = ext_irq_one_req;
	assign timer_zero_raw = timer_zero_req;
	assign ext_irq_zero_raw = ext_irq_zero_req;
	assign timer_three_raw = timer_three_low_overflow | timer_three_high_overflow; // R6
	assign comparator_one_raw = comparator_one_rise_flag | comparator_one_fall_flag; // R7
	assign comparator_zero_raw = comparator_zero_rise_flag | comparator_zero_fall_flag; // R8
	assign counter_array_raw = counter_array_req; // R9
	assign conv_done_raw = conversion_done_flag; // R10
	assign conv_window_raw = window_compare_flag; // R11
	assign calendar_alarm_raw = calendar_alarm_req; // R12
	assign two_wire_raw = two_wire_req; // R13

	// Global enable overrides every individual mask
	assign serial_periph_pend = serial_periph_raw & base_enable_serial_periph & global_irq_enable; // R22
	assign timer_two_pend = timer_two_raw & base_enable_timer_two & global_irq_enable; // R22
	assign async_serial_pend = async_serial_raw & base_enable_async_serial & global_irq_enable; // R22
	assign timer_one_pend = timer_one_raw & base_enable_timer_one & global_irq_enable; // R22
	assign ext_irq_one_pend = ext_irq_one_raw & base_enable_ext_one & global_irq_enable; // R22
	assign timer_zero_pend = timer_zero_raw & base_enable_timer_zero & global_irq_enable; // R22
	assign ext_irq_zero_pend = ext_irq_zero_raw & base_enable_ext_zero & global_irq_enable; // R22
	assign timer_three_pend = timer_three_raw & timer_three_enable & global_irq_enable; // R6 R22
	assign comparator_one_pend = comparator_one_raw & comparator_one_enable & global_irq_enable; // R7
	assign comparator_zero_pend = comparator_zero_raw & comparator_zero_enable & global_irq_enable; // R8
	assign counter_array_pend = counter_array_raw & counter_array_enable & global_irq_enable; // R9
	assign conv_done_pend = conv_done_raw & conv_done_enable & global_irq_enable; // R10
	assign conv_window_pend = conv_window_raw & conv_window_enable & global_irq_enable; // R11
	assign calendar_alarm_pend = calendar_alarm_raw & calendar_alarm_enable & global_irq_enable; // R12
	assign two_wire_pend = two_wire_raw & two_wire_enable & global_irq_enable; // R13

	// Source index order: 14..8 base group, 7..0 first extended group by bit
	assign src_pend = {serial_periph_pend, timer_two_pend, async_serial_pend, timer_one_pend,
		ext_irq_one_pend, timer_zero_pend, ext_irq_zero_pend,
		timer_three_pend, comparator_one_pend, comparator_zero_pend, counter_array_pend,
		conv_done_pend, conv_window_pend, calendar_alarm_pend, two_wire_pend};
	assign src_prio = {serial_periph_prio, timer_two_prio, async_serial_prio, timer_one_prio,
		ext_irq_one_prio, timer_zero_prio, ext_irq_zero_prio,
		timer_three_prio, comparator_one_prio, comparator_zero_prio, counter_array_prio,
		conv_done_prio, conv_window_prio, calendar_alarm_prio, two_wire_prio};
	assign high_req = src_pend & src_prio;
	assign low_req = src_pend & ~src_prio;

	// High requests preempt low service; nothing preempts high service
	assign irq_high = (|high_req) & ~in_high_service; // R23
	assign irq_low = (|low_req) & ~(|high_req) & ~in_high_service & ~in_low_service; // R23

	assign base_prio_out = base_prio_view;
	assign ext_en1_out = ext_en1_q;
	assign ext_prio1_out = ext_prio1_q;
endmodule // ipe_prio_enable

// [ipe_sva.sv]
// Purpose: Register and request gating checks
// Assumes: Bound to ipe_prio_enable
// Notes: Requests are combinational, sampled at mclk
`timescale 1ns/1ps
module ipe_sva (
	input wire mclk, input wire rst, input wire [7:0] sfr_addr, input wire sfr_wr,
	input wire [7:0] sfr_wdata, input wire global_irq_enable, input wire irq_low,
	input wire [14:0] high_req, input wire [14:0] low_req, input wire [7:0] base_prio_out,
	input wire [7:0] ext_en1_out, input wire [7:0] ext_prio1_out, input wire irq_high,
	input wire in_high_service
);
default clocking @(posedge mclk); endclocking
default disable iff (rst);
a_base_wr: assert property (sfr_wr && sfr_addr == 8'hB8 |=>
	base_prio_out == ($past(sfr_wdata) | 8'h80)) else $error("base write");
a_en_wr: assert property (sfr_wr && sfr_addr == 8'hE6 |=>
	ext_en1_out == $past(sfr_wdata)) else $error("enable write");
a_prio_wr: assert property (sfr_wr && sfr_addr == 8'hF6 |=>
	ext_prio1_out == $past(sfr_wdata)) else $error("prio write");
a_en_mask: assert property (
	((high_req[7:0] | low_req[7:0]) & ~ext_en1_out) == 8'h00) else $error("mask");
a_ext_lvl: assert property (
	(high_req[7:0] & ~ext_prio1_out | low_req[7:0] & ext_prio1_out) == 8'h00) else $error("lvl");
a_base_lvl: assert property ((high_req[14:8] & ~base_prio_out[6:0] |
	low_req[14:8] & base_prio_out[6:0]) == 7'h00) else $error("base lvl");
a_gie_gate: assert property (!global_irq_enable |-> (high_req | low_req) == 15'h0000)
	else $error("global gate");
a_high_win: assert property (high_req != 15'h0000 |-> !irq_low)
	else $error("high wins");
a_svc_block: assert property (in_high_service |-> !irq_high && !irq_low)
	else $error("high service blocks");
endmodule // ipe_sva
bind ipe_prio_enable ipe_sva u_sva (.*);

// [ipe_peer.sv]
// Purpose: Peripheral flag and core service model
// Assumes: Flags are levels held until changed
// Notes: Bits 19 and 18 are high and low service
`timescale 1ns/1ps
module ipe_peer (input wire mclk, input wire [19:0] cmd, output reg [19:0] flags = 20'h00000);
always @(posedge mclk) flags <= cmd;
endmodule // ipe_peer

// [ipe_tb.sv]
// Purpose: Directed register and request test
// Assumes: ipe_peer holds the flag levels
// Notes: Base group enables share one level
`timescale 1ns/1ps
module testbench;
reg mclk = 1'h0, rst = 1'h1, sfr_wr = 1'h0, g = 1'h0, be = 1'h1, p;
reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, m;
reg [19:0] cmd = 20'h00000;
wire [19:0] f;
wire [7:0] sfr_rdata;
wire [14:0] hq, lq;
wire ih, il, hit;
integer miscompares = 0, num_checks = 0, i;
ipe_peer peer (.mclk, .cmd, .flags(f));
ipe_prio_enable dut (.mclk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .sfr_hit(hit),
	.global_irq_enable(g), .base_enable_serial_periph(be), .base_enable_timer_two(be),
	.base_enable_async_serial(be), .base_enable_timer_one(be), .base_enable_ext_one(be),
	.base_enable_timer_zero(be), .base_enable_ext_zero(be), .serial_periph_req(f[17]),
	.timer_two_req(f[16]), .async_serial_req(f[15]), .timer_one_req(f[14]),
	.ext_irq_one_req(f[13]), .timer_zero_req(f[12]), .ext_irq_zero_req(f[11]),
	.timer_three_low_overflow(f[10]), .timer_three_high_overflow(f[9]),
	.comparator_one_rise_flag(f[8]), .comparator_one_fall_flag(f[7]),
	.comparator_zero_rise_flag(f[6]), .comparator_zero_fall_flag(f[5]),
	.counter_array_req(f[4]), .conversion_done_flag(f[3]), .window_compare_flag(f[2]),
	.calendar_alarm_req(f[1]), .two_wire_req(f[0]), .in_high_service(f[19]),
	.in_low_service(f[18]), .high_req(hq), .low_req(lq), .irq_high(ih), .irq_low(il),
	.base_prio_out(), .ext_en1_out(), .ext_prio1_out());
initial forever #2 mclk = ~mclk;
initial begin #2000 miscompares = miscompares + 1; print_verdict; end
task chk(input [14:0] got, exp); begin num_checks = num_checks + 1;
	if (got !== exp) begin miscompares = miscompares + 1; $display("MISMATCH %0t %h", $time, got); end
end endtask
task rd(input [7:0] a, e); begin @(posedge mclk) sfr_addr <= a; #1 chk(sfr_rdata, e); end endtask
task wr(input [7:0] a, d); begin @(posedge mclk) sfr_addr <= a; sfr_wdata <= d; sfr_wr <= 1'h1;
	@(posedge mclk) sfr_wr <= 1'h0; end endtask
task print_verdict; begin if (miscompares == 0 && num_checks > 0) $display("Test passed");
	else $display("Test failed"); $finish; end endtask
initial begin
	repeat (5) @(posedge mclk);
	rst <= 1'h0;
	rd(8'hB8, 8'h80); chk(hit, 1'h1);
	rd(8'hE6, 8'h00); rd(8'hF6, 8'h00); rd(8'h5A, 8'h00); chk(hit, 1'h0);
	wr(8'hB8, 8'h55); rd(8'hB8, 8'hD5);
	wr(8'hB8, 8'h2A); rd(8'hB8, 8'hAA);
	// Walk one enable bit; pair flags and level swap between halves
	for (i = 0; i < 16; i = i + 1) begin
		@(posedge mclk) cmd <= {2'h0, 7'h7F, i[3] ? 6'h15 : 6'h2A, 5'h1F}; g <= 1'h1;
		m = 8'h01 << i[2:0]; p = i[3] ^ i[0]; wr(8'hE6, m); wr(8'hF6, p ? m : 8'h00);
		#1 chk(hq, {7'h2A, p ? m : 8'h00});
		chk(lq, {7'h55, p ? 8'h00 : m});
	end
	@(posedge mclk) g <= 1'h0;
	#1 chk(hq | lq, 15'h0000);
	@(posedge mclk) {g, be} <= 2'h2;
	wr(8'hF6, 8'h00); wr(8'hE6, 8'hFF); #1 chk({ih, il}, 2'h1);
	@(posedge mclk) cmd[18] <= 1'h1;
	@(posedge mclk) #1 chk({ih, il}, 2'h0);
	wr(8'hF6, 8'h80); #1 chk({ih, il}, 2'h2);
	@(posedge mclk) cmd[19] <= 1'h1;
	@(posedge mclk) #1 chk({ih, il}, 2'h0);
	@(posedge mclk) rst <= 1'h1;
	repeat (5) @(posedge mclk);
	rst <= 1'h0;
	rd(8'hB8, 8'h80); rd(8'hE6, 8'h00); rd(8'hF6, 8'h00);
	print_verdict;
end
endmodule // testbench
